// File: common/vecexec_pkg.sv
// Constants and carrier types for the string and arbitrary vector executor
package vecexec_pkg;
    // Word and field widths
    localparam int WORD_W = 18;
    localparam int ADDR_W = 17;
    localparam int CODE_W = 7;
    localparam int MAG_W = 10;
    localparam int STR_ADDR_W = 13;
    localparam int CHARS_PER_PAIR = 5;
    // Display word bit n (bit 0 is the MSB) sits at vector index 17-n
    localparam int OPC_HI = 17;
    localparam int OPC_LO = 14;
    // Opcode field values: 04, 10 and 30 octal seen as a 4-bit field
    localparam logic [3:0] OPC_STRING = 4'h1;
    localparam logic [3:0] OPC_LONG_VEC = 4'h2;
    localparam logic [3:0] OPC_SHORT_VEC = 4'h6;
    // Instruction fields
    localparam int STR_IND_BIT = 13;
    localparam int LP_BIT = 13;
    localparam int INT_BIT = 12;
    localparam int SIGN_BIT = 11;
    localparam int MAG_HI = 9;
    localparam int SX_HI = 10;
    localparam int SX_LO = 6;
    localparam int SY_SIGN_BIT = 5;
    localparam int SY_HI = 4;
    // Parameter word fields
    localparam int INCR_HI = 3;
    localparam int ESC_EN_BIT = 11;
    localparam int CR_SEL_BIT = 10;
    localparam int LEVEL_HI = 9;
    localparam int LEVEL_LO = 7;
    localparam int BLINK_EN_BIT = 9;
    localparam int BLINK_ON_BIT = 8;
    localparam int LINE_HI = 1;
    // Form control codes
    localparam logic [6:0] CODE_ALT = 7'h7d;
    localparam logic [6:0] CODE_LF = 7'h0a;
    localparam logic [6:0] CODE_CR = 7'h0d;
    localparam logic [6:0] CODE_TAB = 7'h11;
    // Beam motion for form control and glyph spacing, in grid points
    localparam int TAB_POSITIONS = 9;
    localparam int LF_POSITIONS = 9;
    localparam int CHAR_PITCH = 6;
    localparam logic [MAG_W-1:0] TAB_DX = MAG_W'(TAB_POSITIONS * CHAR_PITCH);
    localparam logic [MAG_W-1:0] LF_DY = MAG_W'(LF_POSITIONS);
    localparam logic [MAG_W-1:0] CHAR_DX = MAG_W'(CHAR_PITCH);
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_PC = 8'h08;
    localparam logic [7:0] OFS_PARAM1 = 8'h0c;
    localparam logic [7:0] OFS_PARAM2 = 8'h10;
    localparam logic [7:0] OFS_PARAM3 = 8'h14;
    localparam logic [7:0] OFS_XPOS = 8'h18;
    localparam logic [7:0] OFS_YPOS = 8'h1c;
    localparam logic [7:0] OFS_HOLD = 8'h20;
    // Control and status bit positions
    localparam int CTRL_START = 0;
    localparam int CTRL_ABORT = 1;
    localparam int STAT_BUSY = 0;
    localparam int STAT_HANG = 1;
    localparam int STAT_FOREIGN = 2;
    localparam int STAT_LAST_CR = 3;
    // Reset values
    localparam logic [ADDR_W-1:0] PC_RST = 17'h00000;
    localparam logic [WORD_W-1:0] PARAM_RST = 18'h00000;

    typedef logic [WORD_W-1:0] word_t;
    typedef logic [ADDR_W-1:0] addr_t;
    typedef logic [CODE_W-1:0] code_t;

    // Character classes
    typedef enum logic [5:0] {
        CLS_ALT = 6'h01,
        CLS_LF = 6'h02,
        CLS_CR = 6'h04,
        CLS_TAB = 6'h08,
        CLS_LEGAL = 6'h10,
        CLS_ILLEGAL = 6'h20
    } char_class_t;

    // Read request toward host memory
    typedef struct packed {
        logic req;
        addr_t addr;
    } mem_req_t;

    // Stroke or move toward the vector generator
    typedef struct packed {
        logic valid;
        logic x_neg;
        logic [MAG_W-1:0] x_mag;
        logic y_neg;
        logic [MAG_W-1:0] y_mag;
        logic intens;
        logic [2:0] level;
        logic lp_en;
        logic blink;
        logic [1:0] dash;
    } vec_cmd_t;

    // Glyph request toward the character generator
    typedef struct packed {
        logic valid;
        code_t code;
        logic [2:0] level;
        logic blink;
        logic [1:0] rotate;
        logic [3:0] scale;
    } glyph_cmd_t;
endpackage

// File: core/char_unpack.sv
// Picks one code out of a packed word pair and classifies it
module char_unpack
    import vecexec_pkg::*;
(
    // Packed pair and position
    input wire word_t i_word1,
    input wire word_t i_word2,
    input wire logic [2:0] i_index,
    // Selected code and its class
    output code_t o_code,
    output char_class_t o_class
);
    // Five codes per pair, last bit of the second word unused
    always_comb begin
        unique case (i_index)
            3'h0: o_code = i_word1[17:11];
            3'h1: o_code = i_word1[10:4];
            3'h2: o_code = {i_word1[3:0], i_word2[17:15]};
            3'h3: o_code = i_word2[14:8];
            3'h4: o_code = i_word2[7:1];
            default: o_code = CODE_ALT; // Unused index ends the string
        endcase
    end

    // Control codes first, otherwise legal when the two top bits differ
    always_comb begin
        if (o_code == CODE_ALT) begin
            o_class = CLS_ALT;
        end else if (o_code == CODE_LF) begin
            o_class = CLS_LF;
        end else if (o_code == CODE_CR) begin
            o_class = CLS_CR;
        end else if (o_code == CODE_TAB) begin
            o_class = CLS_TAB;
        end else if (o_code[6] != o_code[5]) begin
            o_class = CLS_LEGAL;
        end else begin
            o_class = CLS_ILLEGAL;
        end
    end
endmodule // char_unpack

// File: core/vec_string_exec.sv
// Display file executor for character strings and arbitrary vectors
//
// Summary of operation
// - Five codes from two words, last bit unused
// - Indirect bit fetches full 17-bit start address
// - Each legal code is drawn as a glyph
// - Program counter copied to holding register first
// - Held address plus one returns to counter
// - Keep drawing until a terminating code
// - Carriage return ends only when both bits set
// - Tab moves beam nine character positions right
// - Line feed moves beam nine positions down
// - Classify control codes; legal when top bits differ
// - Opcode 10 octal fetches X then Y word
// - Bit 4 light pen, bit 5 intensify
// - Intensity level taken from second parameter word
// - Bit 6 of each word is sign
// - Ten-bit magnitudes from bits 8 to 17
// - Repeat each vector by increment register value
// - Arbitrary vectors are never rotated
// - Blink when blink enable and on set
// - Dash pattern from third parameter line bits
// - Short vector packs both signs and magnitudes
// - Prefetch only for short vectors, never long
// - Opcode 04 octal string, indirect, 13-bit address
//
// The placing of the registers and the APB slave port were chosen for this implementation.
module vec_string_exec
    import vecexec_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic o_pready,
    output logic [31:0] o_prdata,
    output logic o_pslverr,
    // Host memory over the data channel
    output mem_req_t o_mem,
    input wire logic i_mem_ack,
    input wire word_t i_mem_data,
    // Vector and character generators
    output vec_cmd_t o_vec,
    output glyph_cmd_t o_glyph,
    input wire logic i_gen_ready
);
    // Execution states
    typedef enum logic [11:0] {
        ST_IDLE = 12'h001,
        ST_FETCH = 12'h002,
        ST_DECODE = 12'h004,
        ST_STR_PTR = 12'h008,
        ST_STR_W1 = 12'h010,
        ST_STR_W2 = 12'h020,
        ST_STR_CHAR = 12'h040,
        ST_STR_OUT = 12'h080,
        ST_LV_W2 = 12'h100,
        ST_VEC_OUT = 12'h200,
        ST_VEC_WAIT = 12'h400,
        ST_HANG = 12'h800
    } state_t;

    // Whole state of the block
    typedef struct packed {
        state_t state;
        addr_t pc; // Display program counter
        addr_t hold; // Saved counter during a string
        addr_t ptr; // String read pointer
        word_t w1; // Instruction or first packed word
        word_t w2; // Second packed word
        logic [2:0] idx; // Code position inside the pair
        word_t p1;
        word_t p2;
        word_t p3;
        logic [MAG_W-1:0] x; // Beam position kept for software
        logic [MAG_W-1:0] y;
        logic foreign; // Stopped on an opcode not handled here
        logic last_cr; // Last string ended on carriage return
        logic [3:0] rep; // Repeats left for current vector
        logic short_v; // Current vector is the short form
        logic pf_valid; // Prefetched next instruction held
        word_t pf;
        mem_req_t mem;
        vec_cmd_t vec;
        glyph_cmd_t glyph;
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
    } regs_t;

    regs_t r; // Registered state
    regs_t n; // Next state
    code_t cur_code; // Code at the current position
    char_class_t cur_class; // Its class
    logic got; // Memory word arrives this cycle
    logic adv; // Step to the next code
    logic term; // String ends this cycle
    logic wr_fire; // APB write completes at this edge
    logic [3:0] rep_init; // Repeat count, zero means once

    // Code selection from the current pair
    char_unpack u_unpack (
        .i_word1(r.w1),
        .i_word2(r.w2),
        .i_index(r.idx),
        .o_code(cur_code),
        .o_class(cur_class)
    );

    assign got = r.mem.req & i_mem_ack;
    assign wr_fire = i_psel & i_penable & r.pready & i_pwrite;
    assign rep_init = (r.p1[INCR_HI:0] == 4'h0) ? 4'h1 : r.p1[INCR_HI:0];

    // Next state: execution, then register writes, then bus answer
    always_comb begin
        n = r;
        n.pready = 1'b0;
        n.pslverr = 1'b0;
        adv = 1'b0;
        term = 1'b0;
        unique case (r.state)
            ST_IDLE: begin
                // Waits for a start write
            end
            ST_FETCH: begin
                // A prefetched word saves a memory round trip
                if (r.pf_valid) begin
                    n.w1 = r.pf;
                    n.pf_valid = 1'b0;
                    n.state = ST_DECODE;
                end else if (got) begin
                    n.w1 = i_mem_data;
                    n.state = ST_DECODE;
                end
            end
            ST_DECODE: begin
                // Attributes shared by both vector forms; no rotate field exists
                n.vec.lp_en = r.w1[LP_BIT];
                n.vec.intens = r.w1[INT_BIT];
                n.vec.level = r.p2[LEVEL_HI:LEVEL_LO];
                n.vec.blink = r.p2[BLINK_EN_BIT] & r.p2[BLINK_ON_BIT];
                n.vec.dash = r.p3[LINE_HI:0];
                n.rep = rep_init;
                unique case (r.w1[OPC_HI:OPC_LO])
                    OPC_STRING: begin
                        n.hold = r.pc;
                        n.ptr = ADDR_W'(r.w1[STR_ADDR_W-1:0]);
                        n.state = r.w1[STR_IND_BIT] ? ST_STR_PTR : ST_STR_W1;
                    end
                    OPC_LONG_VEC: begin
                        n.pc = r.pc + 17'h1;
                        n.short_v = 1'b0; // No prefetch for the two-word form
                        n.vec.x_neg = r.w1[SIGN_BIT];
                        n.vec.x_mag = r.w1[MAG_HI:0];
                        n.state = ST_LV_W2;
                    end
                    OPC_SHORT_VEC: begin
                        n.pc = r.pc + 17'h1;
                        n.short_v = 1'b1;
                        n.vec.x_neg = r.w1[SIGN_BIT];
                        n.vec.x_mag = MAG_W'(r.w1[SX_HI:SX_LO]);
                        n.vec.y_neg = r.w1[SY_SIGN_BIT];
                        n.vec.y_mag = MAG_W'(r.w1[SY_HI:0]);
                        n.state = ST_VEC_OUT;
                    end
                    default: begin
                        // Other opcodes belong to other units; stop on them
                        n.foreign = 1'b1;
                        n.state = ST_IDLE;
                    end
                endcase
            end
            ST_STR_PTR: begin
                if (got) begin
                    n.ptr = i_mem_data[ADDR_W-1:0];
                    n.state = ST_STR_W1;
                end
            end
            ST_STR_W1: begin
                if (got) begin
                    n.w1 = i_mem_data;
                    n.state = ST_STR_W2;
                end
            end
            ST_STR_W2: begin
                if (got) begin
                    n.w2 = i_mem_data;
                    n.ptr = r.ptr + 17'h2;
                    n.idx = 3'h0;
                    n.state = ST_STR_CHAR;
                end
            end
            ST_STR_CHAR: begin
                // Keep going until a terminator is met
                unique case (cur_class)
                    CLS_ALT: begin
                        term = 1'b1;
                        n.last_cr = 1'b0;
                    end
                    CLS_CR: begin
                        // Carriage return ends only with escape and decision bits
                        if (r.p2[ESC_EN_BIT] & r.p2[CR_SEL_BIT]) begin
                            term = 1'b1;
                            n.last_cr = 1'b1;
                        end else begin
                            adv = 1'b1;
                        end
                    end
                    CLS_TAB: begin
                        n.vec = '0;
                        n.vec.x_mag = TAB_DX;
                        n.vec.valid = 1'b1;
                        n.state = ST_STR_OUT;
                    end
                    CLS_LF: begin
                        n.vec = '0;
                        n.vec.y_neg = 1'b1;
                        n.vec.y_mag = LF_DY;
                        n.vec.valid = 1'b1;
                        n.state = ST_STR_OUT;
                    end
                    CLS_LEGAL: begin
                        // Generator strokes the 5 by 7 glyph
                        n.glyph.code = cur_code;
                        n.glyph.level = r.p2[LEVEL_HI:LEVEL_LO];
                        n.glyph.blink = r.p2[BLINK_EN_BIT] & r.p2[BLINK_ON_BIT];
                        n.glyph.rotate = r.p2[5:4];
                        n.glyph.scale = r.p1[INCR_HI:0];
                        n.glyph.valid = 1'b1;
                        n.state = ST_STR_OUT;
                    end
                    CLS_ILLEGAL: begin
                        adv = 1'b1; // Unprintable codes are skipped
                    end
                endcase
                if (term) begin
                    n.pc = r.hold + 17'h1;
                    n.state = ST_FETCH;
                end
            end
            ST_STR_OUT: begin
                if (i_gen_ready) begin
                    n.vec.valid = 1'b0;
                    n.glyph.valid = 1'b0;
                    n.state = ST_STR_CHAR;
                    adv = 1'b1;
                end
            end
            ST_LV_W2: begin
                if (got) begin
                    n.pc = r.pc + 17'h1;
                    n.vec.y_neg = i_mem_data[SIGN_BIT];
                    n.vec.y_mag = i_mem_data[MAG_HI:0];
                    // Zero length would never normalise; park visibly
                    if ((r.vec.x_mag == '0) && (i_mem_data[MAG_HI:0] == '0)) begin
                        n.state = ST_HANG;
                    end else begin
                        n.state = ST_VEC_OUT;
                    end
                end
            end
            ST_VEC_OUT: begin
                n.vec.valid = 1'b1;
                n.state = ST_VEC_WAIT;
            end
            ST_VEC_WAIT: begin
                if (i_gen_ready) begin
                    n.vec.valid = 1'b0;
                    if (r.rep > 4'h1) begin
                        n.rep = r.rep - 4'h1;
                        n.state = ST_VEC_OUT;
                    end else begin
                        n.state = ST_FETCH;
                    end
                end
            end
            ST_HANG: begin
                // Only an abort or reset leaves this state
            end
        endcase

        // Step through the pair, reading the next pair after the fifth code
        if (adv) begin
            if (r.idx == 3'(CHARS_PER_PAIR - 1)) begin
                n.state = ST_STR_W1;
            end else begin
                n.idx = r.idx + 3'h1;
            end
        end

        // Prefetch word lands while a short vector is drawn
        if (got && ((r.state == ST_VEC_OUT) || (r.state == ST_VEC_WAIT))) begin
            n.pf = i_mem_data;
            n.pf_valid = 1'b1;
        end

        // Beam position follows every accepted move and glyph
        if (r.vec.valid && i_gen_ready) begin
            n.x = r.vec.x_neg ? r.x - r.vec.x_mag : r.x + r.vec.x_mag;
            n.y = r.vec.y_neg ? r.y - r.vec.y_mag : r.y + r.vec.y_mag;
        end else if (r.glyph.valid && i_gen_ready) begin
            n.x = r.x + CHAR_DX;
        end

        // Register writes at the completing edge
        if (wr_fire) begin
            unique case (i_paddr)
                OFS_CTRL: begin
                    if (i_pwdata[CTRL_ABORT]) begin
                        n.state = ST_IDLE;
                        n.vec.valid = 1'b0;
                        n.glyph.valid = 1'b0;
                        n.pf_valid = 1'b0;
                    end else if (i_pwdata[CTRL_START] && (r.state == ST_IDLE)) begin
                        n.state = ST_FETCH;
                        n.foreign = 1'b0;
                        n.pf_valid = 1'b0;
                    end
                end
                OFS_PC: begin
                    // Counter only changes while stopped
                    if (r.state == ST_IDLE) begin
                        n.pc = i_pwdata[ADDR_W-1:0];
                    end
                end
                OFS_PARAM1: n.p1 = i_pwdata[WORD_W-1:0];
                OFS_PARAM2: n.p2 = i_pwdata[WORD_W-1:0];
                OFS_PARAM3: n.p3 = i_pwdata[WORD_W-1:0];
                default: begin
                    // Read-only or unmapped: no effect
                end
            endcase
        end

        // Memory request follows the state being entered
        n.mem.req = 1'b0;
        n.mem.addr = r.mem.addr;
        unique case (n.state)
            ST_FETCH: begin
                n.mem.req = ~n.pf_valid;
                n.mem.addr = n.pc;
            end
            ST_STR_PTR: begin
                n.mem.req = 1'b1;
                n.mem.addr = n.ptr;
            end
            ST_STR_W1: begin
                n.mem.req = 1'b1;
                n.mem.addr = n.ptr;
            end
            ST_STR_W2: begin
                n.mem.req = 1'b1;
                n.mem.addr = n.ptr + 17'h1;
            end
            ST_LV_W2: begin
                n.mem.req = 1'b1;
                n.mem.addr = n.pc;
            end
            ST_VEC_OUT, ST_VEC_WAIT: begin
                n.mem.req = n.short_v & ~n.pf_valid;
                n.mem.addr = n.pc;
            end
            default: begin
                n.mem.req = 1'b0;
            end
        endcase

        // Bus answer one cycle into the access phase
        if (i_psel && i_penable && !r.pready) begin
            n.pready = 1'b1;
            n.prdata = 32'h0;
            unique case (i_paddr)
                OFS_CTRL: n.prdata = 32'h0;
                OFS_STATUS: begin
                    n.prdata[STAT_BUSY] = (r.state != ST_IDLE);
                    n.prdata[STAT_HANG] = (r.state == ST_HANG);
                    n.prdata[STAT_FOREIGN] = r.foreign;
                    n.prdata[STAT_LAST_CR] = r.last_cr;
                end
                OFS_PC: n.prdata = {15'h0, r.pc};
                OFS_PARAM1: n.prdata = {14'h0, r.p1};
                OFS_PARAM2: n.prdata = {14'h0, r.p2};
                OFS_PARAM3: n.prdata = {14'h0, r.p3};
                OFS_XPOS: n.prdata = {22'h0, r.x};
                OFS_YPOS: n.prdata = {22'h0, r.y};
                OFS_HOLD: n.prdata = {15'h0, r.hold};
                default: n.pslverr = 1'b1; // Unmapped address
            endcase
        end
    end

    // State register
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            r <= '0;
            r.state <= ST_IDLE;
            r.pc <= PC_RST;
            r.p1 <= PARAM_RST;
            r.p2 <= PARAM_RST;
            r.p3 <= PARAM_RST;
        end else begin
            r <= n;
        end
    end

    // Outputs straight from the state register
    assign o_pready = r.pready;
    assign o_prdata = r.prdata;
    assign o_pslverr = r.pslverr;
    assign o_mem = r.mem;
    assign o_vec = r.vec;
    assign o_glyph = r.glyph;
endmodule // vec_string_exec

// File: testbench/char_string_arb_vector_exec_bench.sv
// Bench running vector and string display files
`define CHK(a,b) begin check_count++; if ((a)!==(b)) begin num_errors++; $display("CHECK FAILED t=%0t %h %h", $time, a, b); end end
module char_string_arb_vector_exec_bench import vecexec_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk = 0;
    logic i_reset = 1;
    logic psel = 0;
    logic penable = 0;
    logic pwrite = 0;
    logic gen_ready = 0; // Toggles to stall the generators
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0;
    logic [31:0] prdata, rdata;
    logic pready, pslverr, rerr, ack;
    mem_req_t mem;
    word_t mdata;
    vec_cmd_t vec;
    glyph_cmd_t glyph;
    int num_errors = 0;
    int check_count = 0;
    int cyc = 0;
    logic [29:0] vq [$]; // Expected commands in order, valid bit left out
    logic [29:0] ev;
    code_t gq [$]; // Expected glyph codes
    code_t eg;
    always #2.5 i_clk = ~i_clk;
    vec_string_exec uut (.i_clk(i_clk), .i_reset(i_reset), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
        .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr),
        .o_mem(mem), .i_mem_ack(ack), .i_mem_data(mdata), .o_vec(vec), .o_glyph(glyph), .i_gen_ready(gen_ready));
    vecexec_mem_model mm (.i_clk(i_clk), .i_mem(mem), .o_ack(ack), .o_data(mdata));
    // Command key in field order: X sign and magnitude, Y sign and magnitude, intensify, level, light pen, blink, dash
    // Draws carry the level 7, blink on and dash 2 that the bench loads; form moves carry none
    function automatic logic [29:0] mk(logic xn, logic [9:0] xm, logic yn, logic [9:0] ym, logic it, logic lp);
        return {xn, xm, yn, ym, it, it ? 3'h7 : 3'h0, lp, it, it ? 2'h2 : 2'h0};
    endfunction
    // One bus transfer, held until ready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge i_clk);
        penable <= 1;
        do @(posedge i_clk); while (pready !== 1'b1);
        rdata = prdata;
        rerr = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    // Poll status until the run stops
    task automatic wait_idle;
        do apb(0, OFS_STATUS, 0); while (rdata[STAT_BUSY] !== 1'b0);
    endtask
    task automatic print_verdict;
        $display("checks=%0d errors=%0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Check every accepted command; also the hang limit
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        gen_ready <= ~gen_ready;
        if (vec.valid === 1'b1 && gen_ready) begin
            ev = vq.pop_front();
            `CHK(vec[29:0], ev)
        end
        if (glyph.valid === 1'b1 && gen_ready) begin
            eg = gq.pop_front();
            `CHK(glyph.code, eg)
            // Level 7, blink on, no rotate, unit scale
            `CHK(glyph[9:0], {3'h7, 1'b1, 6'h0})
        end
        if (cyc == 20000) begin
            num_errors++;
            print_verdict;
        end
    end
    initial begin
        mm.m[0] = {4'h2, 3'b111, 1'b0, 10'h005};
        mm.m[1] = {6'h3f, 1'b0, 1'b1, 10'h003};
        mm.m[2] = {4'h6, 2'b01, 1'b0, 5'h04, 1'b1, 5'h02};
        mm.m[3] = 18'h3c000;
        mm.m[4] = {4'h1, 1'b1, 13'h00a};
        mm.m[5] = 18'h3c000;
        mm.m[10] = 18'h00010;
        mm.m[16] = {7'h41, 7'h11, 4'h1};
        mm.m[17] = {3'h2, 7'h0d, 7'h7d, 1'b1};
        mm.m[6] = {4'h1, 1'b0, 13'h014}; // Direct string at word 20
        mm.m[7] = 18'h3c000;
        mm.m[20] = {7'h0d, 7'h00, 4'h8}; // CR skipped, illegal skipped
        mm.m[21] = {3'h2, 7'h7f, 7'h0d, 1'b0}; // Glyph, illegal, CR skipped
        mm.m[22] = {7'h7d, 11'h0}; // Terminator opens the second pair
        mm.m[23] = 18'h0;
        vq = '{mk(1, 5, 0, 3, 1, 1), mk(1, 5, 0, 3, 1, 1), mk(0, 4, 1, 2, 1, 0), mk(0, 4, 1, 2, 1, 0),
            mk(0, TAB_DX, 0, 0, 0, 0), mk(0, 0, 1, LF_DY, 0, 0)};
        gq = '{7'h41, 7'h42};
        repeat (12) @(posedge i_clk);
        i_reset <= 0;
        apb(0, OFS_PARAM1, 0);
        `CHK(rdata, 32'h0)
        apb(0, 8'h40, 0);
        `CHK(rerr, 1'b1)
        apb(1, OFS_PARAM2, 32'hf80);
        apb(1, OFS_PARAM3, 32'h2);
        apb(1, OFS_PARAM1, 32'h2);
        apb(1, OFS_PC, 0);
        apb(1, OFS_CTRL, 32'h1);
        wait_idle;
        `CHK(rdata[3:0], 4'h4)
        apb(0, OFS_PC, 0);
        `CHK(rdata, 32'h3)
        $display("vector run done");
        apb(1, OFS_PARAM1, 0);
        apb(1, OFS_PC, 32'h4);
        apb(1, OFS_CTRL, 32'h1);
        wait_idle;
        `CHK(rdata[3:0], 4'hc)
        apb(0, OFS_PC, 0);
        `CHK(rdata, 32'h5)
        apb(0, OFS_HOLD, 0);
        `CHK(rdata, 32'h4)
        $display("string run done");
        // Escape on but decision bit clear: only the alternate-mode code ends
        apb(1, OFS_PARAM2, 32'hb80);
        apb(1, OFS_PC, 32'h6);
        apb(1, OFS_CTRL, 32'h1);
        wait_idle;
        `CHK(rdata[3:0], 4'h4)
        apb(0, OFS_PC, 0);
        `CHK(rdata, 32'h7)
        apb(0, OFS_HOLD, 0);
        `CHK(rdata, 32'h6)
        `CHK(vq.size() + gq.size(), 0)
        $display("direct string run done");
        print_verdict;
    end
endmodule // char_string_arb_vector_exec_bench

// File: testbench/vecexec_checker.sv
// Timing checks on the executor ports
module vecexec_checker import vecexec_pkg::*; (
    // Clock, reset, bus
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic o_pready,
    input wire logic o_pslverr,
    // Memory and generators
    input wire mem_req_t o_mem,
    input wire logic i_mem_ack,
    input wire vec_cmd_t o_vec,
    input wire glyph_cmd_t o_glyph,
    input wire logic i_gen_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_reset);
    a_apb_answer_time: assert property (i_psel && !i_penable ##1 i_psel && i_penable |=> o_pready)
        else $error("bus answer late");
    a_apb_one_pulse: assert property (o_pready |=> !o_pready) else $error("ready too long");
    a_apb_error_pair: assert property (o_pslverr |-> o_pready) else $error("error without ready");
    a_fetch_req_hold: assert property (o_mem.req && !i_mem_ack |=> o_mem.req && $stable(o_mem.addr))
        else $error("fetch dropped");
    a_vec_cmd_hold: assert property (o_vec.valid && !i_gen_ready |=> $stable(o_vec))
        else $error("vector changed");
    a_glyph_cmd_hold: assert property (o_glyph.valid && !i_gen_ready |=> $stable(o_glyph))
        else $error("glyph changed");
    a_single_cmd: assert property (!(o_vec.valid && o_glyph.valid)) else $error("two commands");
    a_glyph_legal: assert property (o_glyph.valid |-> o_glyph.code[6] != o_glyph.code[5])
        else $error("illegal glyph");
    a_reset_quiet: assert property ($fell(i_reset) |-> !o_mem.req && !o_vec.valid && !o_glyph.valid)
        else $error("busy after reset");
    cover property (o_vec.valid && i_gen_ready);
    cover property (o_glyph.valid && i_gen_ready);
    cover property (o_pslverr);
endmodule // vecexec_checker
bind vec_string_exec vecexec_checker chk (.*);

// File: testbench/vecexec_mem_model.sv
// Host memory answering display fetches
module vecexec_mem_model import vecexec_pkg::*; (
    // Clock and request
    input wire logic i_clk,
    input wire mem_req_t i_mem,
    // Answer
    output logic o_ack,
    output word_t o_data
);
    timeunit 1ns;
    timeprecision 1ps;
    word_t m [0:63]; // Small window of the display file
    logic slow = 0; // Alternates prompt and late answers
    // Stall every other cycle so both wait lengths occur
    always @(posedge i_clk) slow <= ~slow;
    assign o_ack = i_mem.req && !slow;
    // Stale cycles show the inverse, so old data cannot pass
    assign o_data = o_ack ? m[i_mem.addr[5:0]] : ~m[i_mem.addr[5:0]];
endmodule // vecexec_mem_model
